// File: dv/byte_bit_op_execute_sva.sv
// Checker for bus answers and port behaviour of the executor
`timescale 1ns/10ps
module byte_bit_op_execute_chk
  import byte_bit_op_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [7:0]  port_pins,
  input wire logic [7:0]  port_latch
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  //////////////////////////////////////////////////////////////////////
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(req))
    else $error("ack without request");
  read_ack_a: assert property (req && !wb_we_i |=> wb_ack_o)
    else $error("read not answered");
  cmd_ack_a: assert property (
    req && wb_we_i && wb_adr_i == CMD_ADDR |-> ##[1:2] wb_ack_o)
    else $error("command not answered");
  write_ack_a: assert property (
    req && wb_we_i && wb_adr_i != CMD_ADDR |=> wb_ack_o)
    else $error("write not answered");
  pin_read_a: assert property (
    wb_ack_o && !$past(wb_we_i)
    && $past(wb_adr_i) == (FILE_BASE | {1'b0, PORT_FADDR, 2'b00})
    |-> wb_dat_o[7:0] == $past(port_pins))
    else $error("port read not from pins");
  latch_cause_a: assert property (
    $changed(port_latch) |-> wb_ack_o && $past(wb_we_i))
    else $error("latch moved without write");
  data_hold_a: assert property (
    $changed(wb_dat_o) |-> wb_ack_o && !$past(wb_we_i))
    else $error("read data moved");
endmodule : byte_bit_op_execute_chk

bind byte_bit_op_execute byte_bit_op_execute_chk chk_inst (
  .clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .port_pins(port_pins), .port_latch(port_latch));

// File: dv/tb.sv
// Self-checking bench for the byte and bit executor
`timescale 1ns/10ps
module tb;
  import byte_bit_op_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0]  wb_adr_i = 8'h00, port_pins = 8'h00, port_latch;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  int          err_total = 0, cmp_count = 0;
  always #25 clock = ~clock;
  byte_bit_op_execute byte_bit_op_execute_inst (
    .clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .port_pins(port_pins), .port_latch(port_latch));
  //////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb
  task cmd(input op_t o, input logic [4:0] f, input logic [2:0] b,
           input logic d, input logic [7:0] k);
    wb(1'b1, CMD_ADDR, {8'h00, k, 4'h0, d, b, f, o});
  endtask : cmd
  task rdc(input logic [7:0] a, input logic [15:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, {16'h0, e});
  endtask : rdc
  task t_add;
    wb(1'b1, ACC_ADDR, 32'hf8);
    wb(1'b1, 8'h8c, 32'h18);
    cmd(OP_ADD_FILE, 5'd3, 3'd0, 1'b0, 8'h00);
    rdc(STAT_ADDR, 16'h0310);
    rdc(8'h8c, 16'h0018);
    cmd(OP_ADD_FILE, 5'd3, 3'd0, 1'b1, 8'h00);
    rdc(8'h8c, 16'h0028);
    rdc(STAT_ADDR, 16'h0010);
    wb(1'b1, ACC_ADDR, 32'h09);
    cmd(OP_ADD_FILE, 5'd3, 3'd0, 1'b0, 8'h00);
    rdc(STAT_ADDR, 16'h0231);
    wb(1'b1, ACC_ADDR, 32'hd8);
    cmd(OP_ADD_FILE, 5'd3, 3'd0, 1'b0, 8'h00);
    rdc(STAT_ADDR, 16'h0700);
  endtask : t_add
  task t_and;
    wb(1'b1, ACC_ADDR, 32'h5a);
    cmd(OP_AND_IMM, 5'd0, 3'd0, 1'b0, 8'ha5);
    rdc(STAT_ADDR, 16'h0700);
    wb(1'b1, ACC_ADDR, 32'hff);
    cmd(OP_AND_IMM, 5'd0, 3'd0, 1'b0, 8'hff);
    rdc(STAT_ADDR, 16'h03ff);
    wb(1'b1, 8'h90, 32'h3c);
    wb(1'b1, ACC_ADDR, 32'h0f);
    cmd(OP_AND_FILE, 5'd4, 3'd0, 1'b1, 8'h00);
    rdc(8'h90, 16'h000c);
    rdc(STAT_ADDR, 16'h030f);
    wb(1'b1, ACC_ADDR, 32'hf0);
    cmd(OP_AND_FILE, 5'd4, 3'd0, 1'b0, 8'h00);
    rdc(STAT_ADDR, 16'h0700);
  endtask : t_and
  task t_bits;
    for (int i = 0; i < 8; i++) begin
      cmd(OP_BIT_SET, 5'd31, 3'(i), 1'b0, 8'h00);
      rdc(8'hfc, 16'((2 << i) - 1));
    end
    for (int i = 0; i < 8; i++) begin
      cmd(OP_BIT_CLEAR, 5'd31, 3'(i), 1'b1, 8'h00);
      rdc(8'hfc, 16'((16'hff << (i + 1)) & 16'hff));
    end
    cmd(OP_NOP, 5'd3, 3'd0, 1'b0, 8'h00);
    rdc(STAT_ADDR, 16'h0700);
  endtask : t_bits
  task t_skip;
    logic tk;
    for (int i = 0; i < 4; i++) begin
      tk = (i[1] == i[0]);
      wb(1'b1, 8'h94, {31'h0, i[0]});
      cmd(i[1] ? OP_SKIP_ONE : OP_SKIP_ZERO, 5'd5, 3'd0, 1'b0, 8'h00);
      rdc(STAT_ADDR, {4'h0, tk, 11'h700});
      cmd(OP_BIT_SET, 5'd5, 3'd7, 1'b0, 8'h00);
      rdc(8'h94, {8'h00, ~tk, 6'h00, i[0]});
      rdc(STAT_ADDR, {3'h0, tk, 12'h700});
    end
  endtask : t_skip
  task t_port;
    port_pins <= 8'ha5;
    cmd(OP_BIT_SET, 5'd6, 3'd1, 1'b0, 8'h00);
    chk({24'h0, port_latch}, 32'ha7);
    rdc(8'h98, 16'h00a5);
    wb(1'b1, ACC_ADDR, 32'h0f);
    port_pins <= 8'h3c;
    cmd(OP_AND_FILE, 5'd6, 3'd0, 1'b1, 8'h00);
    chk({24'h0, port_latch}, 32'h0c);
  endtask : t_port
  task conclude;
    $display("errors=%0d compares=%0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  initial begin
    repeat (5000) @(posedge clock);
    err_total++;
    conclude;
  end
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_add;
    t_and;
    t_bits;
    t_skip;
    t_port;
    conclude;
  end
endmodule : tb

// File: verilog/byte_bit_op_execute.sv
// Byte and bit operation executor with a classic Wishbone register slave
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
// Summary of operation
// - Add updates carry, nibble overflow, zero flags
// - Direction bit 0 to acc, 1 to file
// - Bit clear zeroes selected bit, flags untouched
// - Bit set forces selected bit, flags untouched
// - AND immediate into acc, zero flag only
// - AND file routed by direction, zero only
// - Skip next when tested bit is zero
// - Skip next when tested bit is one
// - Taken skip discards next, runs no-op, two cycles
// - Port read-modify-write uses pin levels
module byte_bit_op_execute
  import byte_bit_op_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic [DATA_W-1:0]  port_pins,
  output logic      [DATA_W-1:0]  port_latch
);

  typedef enum logic {S_RUN, S_NOP} state_t;

  state_t              state_q;
  logic [DATA_W-1:0]   acc_q;
  flags_t              flags_q;
  logic [DATA_W-1:0]   file_q [FILE_DEPTH];
  logic                skip_pend_q;
  logic                discard_q;
  logic                ack_q;
  logic [31:0]         rdata_q;

  logic                req;
  logic                is_cmd;
  logic                is_acc;
  logic                is_file;
  logic [FADDR_W-1:0]  bus_fidx;
  logic                stall;
  logic                exec;
  cmd_t                cmd;
  logic [DATA_W-1:0]   operand;
  logic [DATA_W:0]     sum;
  logic [4:0]          nib_sum;
  logic [DATA_W-1:0]   result;
  logic                tested;
  logic                skip_take;
  logic                writes_acc;
  logic                writes_file;
  flags_t              flags_d;

  // File read; the port location returns the pin levels
  function automatic logic [DATA_W-1:0] file_read(
    input logic [FADDR_W-1:0] idx,
    input logic [DATA_W-1:0]  pins,
    input logic [DATA_W-1:0]  stored
  );
    if (idx == PORT_FADDR) begin
      return pins;
    end
    return stored;
  endfunction : file_read

  //////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign req      = wb_cyc_i && wb_stb_i && !ack_q;
  assign is_cmd   = (wb_adr_i == CMD_ADDR);
  assign is_acc   = (wb_adr_i == ACC_ADDR);
  assign is_file  = (wb_adr_i >= FILE_BASE);
  assign bus_fidx = wb_adr_i[FILE_IDX_LO +: FADDR_W];
  // A command waits while the no-op slot of a taken skip runs
  assign stall    = wb_we_i && is_cmd && (state_q == S_NOP);
  assign exec     = req && !stall && wb_we_i && is_cmd;
  assign cmd      = cmd_t'(wb_dat_i);
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign port_latch = file_q[PORT_FADDR];

  //////////////////////////////////////////////////////////////////////////
  // Datapath

  always_comb begin
    operand     = file_read(cmd.faddr, port_pins, file_q[cmd.faddr]);
    sum         = {1'b0, acc_q} + {1'b0, operand};
    nib_sum     = {1'b0, acc_q[NIBBLE_MSB:0]} + {1'b0, operand[NIBBLE_MSB:0]};
    tested      = operand[cmd.bit_sel];
    result      = operand;
    flags_d     = flags_q;
    skip_take   = 1'b0;
    writes_acc  = 1'b0;
    writes_file = 1'b0;
    unique case (cmd.op)
      OP_NOP: begin
      end
      OP_ADD_FILE: begin
        result = sum[DATA_W-1:0];
        flags_d.carry = sum[DATA_W];
        flags_d.nibble_overflow_bit = nib_sum[4];
        flags_d.zero = (result == '0);
        writes_acc  = !cmd.dest_file;
        writes_file = cmd.dest_file;
      end
      OP_AND_IMM: begin
        result = acc_q & cmd.literal;
        flags_d.zero = (result == '0);
        writes_acc = 1'b1;
      end
      OP_AND_FILE: begin
        result = acc_q & operand;
        flags_d.zero = (result == '0);
        writes_acc  = !cmd.dest_file;
        writes_file = cmd.dest_file;
      end
      OP_BIT_CLEAR: begin
        result[cmd.bit_sel] = 1'b0;
        writes_file = 1'b1;
      end
      OP_BIT_SET: begin
        result[cmd.bit_sel] = 1'b1;
        writes_file = 1'b1;
      end
      OP_SKIP_ZERO: begin
        skip_take = !tested;
      end
      OP_SKIP_ONE: begin
        skip_take = tested;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Wishbone answer: one wait state, then ack for a single cycle

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !stall;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (req && !wb_we_i) begin
      rdata_q <= '0;
      if (wb_adr_i == STAT_ADDR) begin
        rdata_q[DATA_W-1:0] <= acc_q;
        rdata_q[ST_CARRY]   <= flags_q.carry;
        rdata_q[ST_NIBBLE]  <= flags_q.nibble_overflow_bit;
        rdata_q[ST_ZERO]    <= flags_q.zero;
        rdata_q[ST_SKIP]    <= skip_pend_q;
        rdata_q[ST_DISCARD] <= discard_q;
        rdata_q[ST_BUSY]    <= (state_q == S_NOP);
      end else if (is_acc) begin
        rdata_q[DATA_W-1:0] <= acc_q;
      end else if (is_file) begin
        rdata_q[DATA_W-1:0] <= file_read(bus_fidx, port_pins,
                                         file_q[bus_fidx]);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Execution sequencing

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= S_RUN;
    end else if (exec && !skip_pend_q && skip_take) begin
      state_q <= S_NOP;
    end else begin
      state_q <= S_RUN;
    end
  end

  // The command after a taken skip is the one already fetched: drop it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      skip_pend_q <= 1'b0;
      discard_q   <= 1'b0;
    end else if (exec) begin
      discard_q   <= skip_pend_q;
      skip_pend_q <= !skip_pend_q && skip_take;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      acc_q   <= ACC_RESET;
      flags_q <= '0;
    end else if (exec && !skip_pend_q) begin
      flags_q <= flags_d;
      if (writes_acc) begin
        acc_q <= result;
      end
    end else if (req && wb_we_i && is_acc && wb_sel_i[0]) begin
      acc_q <= wb_dat_i[DATA_W-1:0];
    end
  end

  generate
    for (genvar i = 0; i < FILE_DEPTH; i++) begin : g_file
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          file_q[i] <= FILE_RESET;
        end else if (exec && !skip_pend_q && writes_file
                     && cmd.faddr == FADDR_W'(i)) begin
          file_q[i] <= result;
        end else if (req && wb_we_i && is_file && wb_sel_i[0]
                     && bus_fidx == FADDR_W'(i)) begin
          file_q[i] <= wb_dat_i[DATA_W-1:0];
        end
      end
    end
  endgenerate

endmodule : byte_bit_op_execute

// File: verilog/byte_bit_op_pkg.sv
// Package: register map, command layout and opcodes of the byte/bit executor
package byte_bit_op_pkg;

  localparam int          DATA_W      = 8;
  localparam int          FILE_DEPTH  = 32;
  localparam int          FADDR_W     = 5;
  localparam int          BIT_W       = 3;
  localparam logic [4:0]  PORT_FADDR  = 5'h06;
  localparam logic [3:0]  NIBBLE_MSB  = 4'h3;

  // Wishbone byte addresses
  localparam logic [7:0]  CMD_ADDR    = 8'h00;
  localparam logic [7:0]  STAT_ADDR   = 8'h04;
  localparam logic [7:0]  ACC_ADDR    = 8'h08;
  localparam logic [7:0]  FILE_BASE   = 8'h80;
  localparam int          FILE_IDX_LO = 2;

  // Status register field positions
  localparam int          ST_CARRY    = 8;
  localparam int          ST_NIBBLE   = 9;
  localparam int          ST_ZERO     = 10;
  localparam int          ST_SKIP     = 11;
  localparam int          ST_DISCARD  = 12;
  localparam int          ST_BUSY     = 13;

  localparam logic [7:0]  ACC_RESET   = 8'h00;
  localparam logic [7:0]  FILE_RESET  = 8'h00;

  typedef enum logic [2:0] {
    OP_NOP,
    OP_ADD_FILE,
    OP_AND_IMM,
    OP_AND_FILE,
    OP_BIT_CLEAR,
    OP_BIT_SET,
    OP_SKIP_ZERO,
    OP_SKIP_ONE
  } op_t;

  // Command word, high bits first
  typedef struct packed {
    logic [7:0]   unused_hi;
    logic [7:0]   literal;
    logic [3:0]   unused_mid;
    logic         dest_file;
    logic [2:0]   bit_sel;
    logic [4:0]   faddr;
    op_t          op;
  } cmd_t;

  typedef struct packed {
    logic zero;
    logic nibble_overflow_bit;
    logic carry;
  } flags_t;

endpackage : byte_bit_op_pkg
